// ### rtl/sdwl_pkg.sv
// Shared constants and types for the serial converter word loader
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package sdwl_pkg;

    //------------------------------------------------------------------
    // Word layout
    //------------------------------------------------------------------
    localparam int SDWL_WORD_W      = 16;
    localparam int SDWL_CODE_W      = 12;
    localparam int SDWL_MODE_HI_POS = 13;
    localparam int SDWL_MODE_LO_POS = 12;
    localparam int SDWL_CODE_MSB    = 11;
    localparam int SDWL_BITS_W      = 5;

    //------------------------------------------------------------------
    // Types
    //------------------------------------------------------------------
    typedef logic [SDWL_WORD_W-1:0] sdwl_word_t;
    typedef logic [SDWL_CODE_W-1:0] sdwl_code_t;
    typedef logic [SDWL_BITS_W-1:0] sdwl_bits_t;

    typedef enum logic [1:0]
    {
        SDWL_MODE_NORMAL  = 2'h0,
        SDWL_MODE_PD_1K   = 2'h1,
        SDWL_MODE_PD_100K = 2'h2,
        SDWL_MODE_PD_HIZ  = 2'h3
    } sdwl_mode_t;

    //------------------------------------------------------------------
    // Reset values and counts
    //------------------------------------------------------------------
    localparam sdwl_word_t SDWL_WORD_RST  = 16'h0000;
    localparam sdwl_code_t SDWL_CODE_RST  = 12'h000;
    localparam sdwl_bits_t SDWL_BITS_RST  = 5'h00;
    localparam sdwl_bits_t SDWL_BITS_FULL = 5'h10;
    localparam sdwl_bits_t SDWL_BITS_ONE  = 5'h01;
    localparam logic [2:0] SDWL_TERM_RST  = 3'h0;
    localparam logic       SDWL_FRAME_IDLE = 1'b1;

endpackage

// ### rtl/sdwl_sync2.sv
// Two-flop level synchroniser with asynchronous clear to a constant
`timescale 1ns/100ps

module sdwl_sync2
#(
    parameter logic RESET_VALUE = 1'b0
)
(
    input  wire logic i_clock,
    input  wire logic i_async_zero_n,
    input  wire logic i_level,
    output logic      o_level
);

    logic first_stage;

    //------------------------------------------------------------------
    // Only the second stage is read outside this module
    //------------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_async_zero_n)
    begin
        if (!i_async_zero_n)
        begin
            first_stage <= RESET_VALUE;
            o_level     <= RESET_VALUE;
        end
        else
        begin
            first_stage <= i_level;
            o_level     <= first_stage;
        end
    end

endmodule

// ### rtl/sdwl_loader.sv
// Serial word loader: link shift register, frame update and power modes
`timescale 1ns/100ps

module sdwl_loader
    import sdwl_pkg::*;
(
    input  wire logic               i_clock,
    input  wire logic               i_sys_rst,
    input  wire logic               i_async_zero_n,
    input  wire logic               i_shift_clk,
    input  wire logic               i_frame_n,
    input  wire logic               i_serial_in,
    output logic                    o_serial_out,
    output logic                    o_serial_out_oe,
    output logic [SDWL_CODE_W-1:0]  o_code,
    output logic                    o_down_mode_hi,
    output logic                    o_down_mode_lo,
    output logic                    o_out_on,
    output logic                    o_term_1k,
    output logic                    o_term_100k,
    output logic                    o_term_hiz,
    output logic                    o_update,
    output logic                    o_short_frame
);

    //------------------------------------------------------------------
    // Helper functions
    //------------------------------------------------------------------
    function automatic sdwl_mode_t mode_of(input sdwl_word_t word);
        // Top two control bits are don't-care
        return sdwl_mode_t'({word[SDWL_MODE_HI_POS], word[SDWL_MODE_LO_POS]});
    endfunction

    function automatic sdwl_code_t code_of(input sdwl_word_t word);
        // Straight binary, 0 to 4095
        return word[SDWL_CODE_MSB:0];
    endfunction

    function automatic logic [2:0] term_of(input sdwl_mode_t mode);
        logic [2:0] term;
        term = SDWL_TERM_RST;
        unique case (mode)
            SDWL_MODE_NORMAL:  term = SDWL_TERM_RST;
            SDWL_MODE_PD_1K:   term = 3'h1;
            SDWL_MODE_PD_100K: term = 3'h2;
            SDWL_MODE_PD_HIZ:  term = 3'h4;
        endcase
        return term;
    endfunction

    function automatic sdwl_bits_t bits_step(input sdwl_bits_t bits);
        // Count saturates once a whole word has gone past
        if (bits >= SDWL_BITS_FULL)
        begin
            return SDWL_BITS_FULL;
        end
        return sdwl_bits_t'(bits + SDWL_BITS_ONE);
    endfunction

    //------------------------------------------------------------------
    // Link domain state (falling edges of the shift clock)
    //------------------------------------------------------------------
    typedef struct packed
    {
        sdwl_word_t shift;
        sdwl_bits_t bits;
        logic       full;
    } sdwl_link_t;

    localparam sdwl_link_t LINK_RST = '{
        shift: SDWL_WORD_RST,
        bits:  SDWL_BITS_RST,
        full:  1'b0
    };

    sdwl_link_t link;
    sdwl_link_t next_link;

    always_comb
    begin
        next_link = link;
        if (!i_frame_n)
        begin
            // MSB arrives first and ends up at the top
            next_link.shift = {link.shift[SDWL_WORD_W-2:0], i_serial_in};
            next_link.bits  = bits_step(link.bits);
            next_link.full  = (bits_step(link.bits) >= SDWL_BITS_FULL);
        end
        else
        begin
            // Edge after the frame re-arms the bit count for the next frame
            next_link.bits = SDWL_BITS_RST;
        end
    end

    always_ff @(negedge i_shift_clk or negedge i_async_zero_n)
    begin
        if (!i_async_zero_n)
        begin
            link <= LINK_RST;
        end
        else
        begin
            link <= next_link;
        end
    end

    //------------------------------------------------------------------
    // Serial output drive
    //------------------------------------------------------------------
    // Enable is released at once when the frame ends, and is taken
    // at the first falling edge inside a frame
    logic out_drive;

    always_ff @(negedge i_shift_clk or posedge i_frame_n or negedge i_async_zero_n)
    begin
        if (!i_async_zero_n)
        begin
            out_drive <= 1'b0;
        end
        else if (i_frame_n)
        begin
            out_drive <= 1'b0;
        end
        else
        begin
            out_drive <= 1'b1;
        end
    end

    // The shift register end lags the input by 16 falling edges
    assign o_serial_out    = link.shift[SDWL_WORD_W-1];
    assign o_serial_out_oe = out_drive;

    //------------------------------------------------------------------
    // Frame select crossing into the system clock
    //------------------------------------------------------------------
    logic frame_sync;

    sdwl_sync2
    #(
        .RESET_VALUE (SDWL_FRAME_IDLE)
    )
    u_frame_sync
    (
        .i_clock        (i_clock),
        .i_async_zero_n (i_async_zero_n),
        .i_level        (i_frame_n),
        .o_level        (frame_sync)
    );

    //------------------------------------------------------------------
    // Clear release into the system clock
    //------------------------------------------------------------------
    // Clear still takes the system registers at once, but lets go of
    // them only after two clock edges, so no flop sees a late release
    logic sys_clear_n;

    sdwl_sync2
    #(
        .RESET_VALUE (1'b0)
    )
    u_clear_sync
    (
        .i_clock        (i_clock),
        .i_async_zero_n (i_async_zero_n),
        .i_level        (1'b1),
        .o_level        (sys_clear_n)
    );

    //------------------------------------------------------------------
    // System domain state
    //------------------------------------------------------------------
    typedef struct packed
    {
        logic       frame_prev;
        sdwl_code_t code;
        sdwl_mode_t mode;
        logic [2:0] term;
        logic       out_on;
        logic       update;
        logic       short_frame;
    } sdwl_sys_t;

    localparam sdwl_sys_t SYS_RST = '{
        frame_prev:  SDWL_FRAME_IDLE,
        code:        SDWL_CODE_RST,
        mode:        SDWL_MODE_NORMAL,
        term:        SDWL_TERM_RST,
        out_on:      1'b1,
        update:      1'b0,
        short_frame: 1'b0
    };

    sdwl_sys_t  sys;
    sdwl_sys_t  next_sys;
    logic       frame_rise;
    sdwl_word_t captured;
    sdwl_mode_t captured_mode;
    sdwl_code_t captured_code;

    // Shift word is frozen while frame select is high, so the
    // synchronised frame edge acts as the handshake for the word
    assign frame_rise = frame_sync & ~sys.frame_prev;
    assign captured   = link.shift;

    // Word is decoded once and shared by every field it feeds
    assign captured_mode = mode_of(captured);
    assign captured_code = code_of(captured);

    always_comb
    begin
        next_sys            = sys;
        next_sys.frame_prev = frame_sync;
        next_sys.update     = 1'b0;
        // Only a rising frame edge may change the output
        if (frame_rise)
        begin
            next_sys.update      = 1'b1;
            next_sys.short_frame = ~link.full;
            next_sys.mode        = captured_mode;
            next_sys.term        = term_of(captured_mode);
            if (captured_mode == SDWL_MODE_NORMAL)
            begin
                // Leaves power-down and loads the code together
                next_sys.code   = captured_code;
                next_sys.out_on = 1'b1;
            end
            else
            begin
                // Data bits are don't-care; last code is kept
                next_sys.out_on = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clock or negedge sys_clear_n)
    begin
        if (!sys_clear_n)
        begin
            sys <= SYS_RST;
        end
        else if (i_sys_rst)
        begin
            sys <= SYS_RST;
        end
        else
        begin
            sys <= next_sys;
        end
    end

    //------------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------------
    assign o_code         = sys.code;
    assign o_down_mode_hi = sys.mode[1];
    assign o_down_mode_lo = sys.mode[0];
    assign o_out_on       = sys.out_on;
    assign o_term_1k      = sys.term[0];
    assign o_term_100k    = sys.term[1];
    assign o_term_hiz     = sys.term[2];
    assign o_update       = sys.update;
    assign o_short_frame  = sys.short_frame;

endmodule

// ### test/sdwl_loader_chk.sv
// Concurrent checks on the serial word loader ports
`timescale 1ns/100ps

module sdwl_loader_chk
    import sdwl_pkg::*;
(
    input  wire logic                   i_clock,
    input  wire logic                   i_sys_rst,
    input  wire logic                   i_async_zero_n,
    input  wire logic                   i_shift_clk,
    input  wire logic                   i_frame_n,
    input  wire logic                   i_serial_in,
    input  wire logic                   o_serial_out,
    input  wire logic                   o_serial_out_oe,
    input  wire logic [SDWL_CODE_W-1:0] o_code,
    input  wire logic                   o_down_mode_hi,
    input  wire logic                   o_down_mode_lo,
    input  wire logic                   o_out_on,
    input  wire logic                   o_term_1k,
    input  wire logic                   o_term_100k,
    input  wire logic                   o_term_hiz,
    input  wire logic                   o_update
);
    //------------------------------------------------------------------
    // Consecutive shifting edges in the current frame, saturating at 16
    //------------------------------------------------------------------
    logic [4:0] run;
    always_ff @(negedge i_shift_clk or negedge i_async_zero_n)
    begin
        if (!i_async_zero_n)
            run <= 5'h00;
        else if (i_frame_n)
            run <= 5'h00;
        else if (run != 5'h10)
            run <= run + 5'h01;
    end

    sequence frame_end;
        $rose(i_frame_n);
    endsequence
    sequence upd_soon;
        ##[2:4] o_update;
    endsequence
    sequence in_frame;
        !i_frame_n ##1 !i_frame_n;
    endsequence

    chk_clear_zero: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        !i_async_zero_n |-> o_code == 12'h000 && !o_down_mode_hi && !o_down_mode_lo && o_out_on)
        else $error("clear did not force zero code");
    chk_power_zero: assert property (@(posedge i_clock) disable iff (!i_async_zero_n)
        $fell(i_sys_rst) |-> o_code == 12'h000 && o_out_on && !o_down_mode_hi)
        else $error("reset state is not zero scale");
    chk_only_update: assert property (@(posedge i_clock)
        disable iff (i_sys_rst || !i_async_zero_n)
        $changed({o_code, o_down_mode_hi, o_down_mode_lo}) |-> o_update)
        else $error("output changed without an update");
    chk_update_pulse: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        o_update |=> !o_update)
        else $error("update pulse too long");
    chk_frame_update: assert property (@(posedge i_clock)
        disable iff (i_sys_rst || !i_async_zero_n) frame_end |-> upd_soon)
        else $error("frame end not followed by update");
    chk_mode_terms: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        o_term_1k == ({o_down_mode_hi, o_down_mode_lo} == 2'h1)
        && o_term_100k == ({o_down_mode_hi, o_down_mode_lo} == 2'h2)
        && o_term_hiz == ({o_down_mode_hi, o_down_mode_lo} == 2'h3)
        && o_out_on == ({o_down_mode_hi, o_down_mode_lo} == 2'h0))
        else $error("termination does not match mode");
    chk_oe_idle: assert property (@(posedge i_clock) disable iff (!i_async_zero_n)
        i_frame_n |-> !o_serial_out_oe)
        else $error("serial output driven outside frame");
    chk_oe_frame: assert property (@(negedge i_shift_clk) disable iff (!i_async_zero_n)
        in_frame |-> o_serial_out_oe)
        else $error("serial output not driven in frame");
    chk_daisy_delay: assert property (@(negedge i_shift_clk) disable iff (!i_async_zero_n)
        (run == 5'h10 && !i_frame_n) |-> o_serial_out == $past(i_serial_in, 16))
        else $error("serial output is not input delayed by 16");
endmodule

bind sdwl_loader sdwl_loader_chk chk (.i_clock, .i_sys_rst, .i_async_zero_n, .i_shift_clk,
    .i_frame_n, .i_serial_in, .o_serial_out, .o_serial_out_oe, .o_code, .o_down_mode_hi,
    .o_down_mode_lo, .o_out_on, .o_term_1k, .o_term_100k, .o_term_hiz, .o_update);

// ### test/sdwl_host_model.sv
// Host side of the serial link: frames words onto the shift clock
`timescale 1ns/100ps

module sdwl_host_model
(
    output logic o_shift_clk,
    output logic o_frame_n,
    output logic o_serial_in
);
    initial
    begin
        o_shift_clk = 1'b0;
        o_frame_n   = 1'b1;
        o_serial_in = 1'b0;
    end

    // Clock runs within a frame plus one trailing pulse after frame select rises, 15 ns period
    task automatic send(input logic [23:0] w, input int n);
        o_frame_n = 1'b0;
        #5;
        for (int i = n - 1; i >= 0; i--)
        begin
            o_serial_in = w[i];
            o_shift_clk = 1'b1;
            #7.5;
            o_shift_clk = 1'b0;
            #7.5;
        end
        o_serial_in = ~o_serial_in;
        o_frame_n   = 1'b1;
        #7.5;
        o_shift_clk = 1'b1;
        #7.5;
        o_shift_clk = 1'b0;
        o_serial_in = ~o_serial_in;
    endtask
endmodule

// ### test/sdwl_loader_tb.sv
// Self-checking bench for the serial word loader
`timescale 1ns/100ps

module sdwl_loader_tb;
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_async_zero_n = 1'b1;
    logic shift_clk, frame_n, serial_in, serial_out, oe;
    logic mode_hi, mode_lo, out_on, t1k, t100k, thiz, upd, short_f;
    sdwl_pkg::sdwl_code_t code;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #12.5 i_clock = ~i_clock;

    sdwl_host_model host (.o_shift_clk(shift_clk), .o_frame_n(frame_n), .o_serial_in(serial_in));

    sdwl_loader dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_async_zero_n(i_async_zero_n),
        .i_shift_clk(shift_clk), .i_frame_n(frame_n), .i_serial_in(serial_in),
        .o_serial_out(serial_out), .o_serial_out_oe(oe), .o_code(code),
        .o_down_mode_hi(mode_hi), .o_down_mode_lo(mode_lo), .o_out_on(out_on),
        .o_term_1k(t1k), .o_term_100k(t100k), .o_term_hiz(thiz), .o_update(upd),
        .o_short_frame(short_f));

    //------------------------------------------------------------------
    // Shared tasks
    //------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check_state(input logic [1:0] md, input logic [11:0] cd);
        check({4'h0, code}, {4'h0, cd});
        check({14'h0, mode_hi, mode_lo}, {14'h0, md});
        check({12'h0, out_on, t1k, t100k, thiz}, {12'h0, 4'b1000 >> md});
    endtask

    // Sends a frame, waits for its update, then judges the new state
    task automatic s_word(input logic [23:0] w, input int n, input logic [1:0] md,
                          input logic [11:0] cd, input logic sh);
        host.send(w, n);
        for (int k = 0; k < 40 && upd !== 1'b1; k++)
        begin
            @(posedge i_clock);
            #1;
        end
        check({15'h0, upd}, 16'h0001);
        check_state(md, cd);
        check({15'h0, short_f}, {15'h0, sh});
    endtask

    //------------------------------------------------------------------
    // Scenarios
    //------------------------------------------------------------------
    task automatic s_power_on();
        check_state(2'h0, 12'h000);
        check({15'h0, oe}, 16'h0000);
    endtask

    task automatic s_modes();
        s_word(24'h00_CABC, 16, 2'h0, 12'hABC, 1'b0);
        s_word(24'h00_1FFF, 16, 2'h1, 12'hABC, 1'b0);
        s_word(24'h00_2123, 16, 2'h2, 12'hABC, 1'b0);
        s_word(24'h00_3000, 16, 2'h3, 12'hABC, 1'b0);
        s_word(24'h00_4FFF, 16, 2'h0, 12'hFFF, 1'b0);
    endtask

    task automatic s_daisy_short();
        s_word(24'hAB_C123, 24, 2'h0, 12'h123, 1'b0);
        check({15'h0, serial_out}, 16'h0001);
        check({15'h0, oe}, 16'h0000);
        s_word(24'h00_0065, 8, 2'h2, 12'h123, 1'b1);
    endtask

    task automatic s_clear();
        @(posedge i_clock);
        i_async_zero_n <= 1'b0;
        #2;
        check_state(2'h0, 12'h000);
        repeat (2) @(posedge i_clock);
        i_async_zero_n <= 1'b1;
        repeat (10) @(posedge i_clock);
        #1;
        check({4'h0, code}, 16'h0000);
        s_word(24'h00_00A5, 8, 2'h0, 12'h0A5, 1'b1);
    endtask

    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            miscompares++;
            conclude();
        end
    end

    initial
    begin
        // Clear falls as an event so every cleared register takes it
        i_async_zero_n <= 1'b0;
        repeat (3) @(posedge i_clock);
        i_sys_rst      <= 1'b0;
        i_async_zero_n <= 1'b1;
        repeat (4) @(posedge i_clock);
        #1;
        s_power_on();
        s_modes();
        s_daisy_short();
        s_clear();
        conclude();
    end
endmodule
